// file: iscd_compare.sv
`timescale 1ns/100ps
module iscd_compare (
    // operands
    input  wire logic [31:0] lhs,
    input  wire logic [31:0] rhs,
    // flags
    output logic             signedLess,
    output logic             unsignedLess,
    output logic             equal,
    // difference
    output logic [31:0]      difference
);
    always_comb begin
        signedLess   = $signed(lhs) < $signed(rhs);
        unsignedLess = lhs < rhs;
        equal        = lhs == rhs;
        difference   = lhs - rhs;
    end
endmodule

// file: iscd_datapath.sv
`timescale 1ns/100ps
module iscd_datapath (
    // clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    // issue from decoder
    input  wire logic                                   issueValid,
    output logic                                        issueReady,
    input  wire iscd_pkg::iscd_issue_t                  issue,
    input  wire logic                                   linkFlag,
    input  wire logic [iscd_pkg::SHADOW_W-1:0]          previousShadowSetField,
    // shadow register read port
    output logic [iscd_pkg::SHADOW_W-1:0]               shadowSet,
    output logic [iscd_pkg::REG_IDX_W-1:0]              shadowIndex,
    input  wire logic [iscd_pkg::DATA_W-1:0]            shadowData,
    // register file write back
    output iscd_pkg::iscd_wb_t                          writeBack,
    // memory store port
    output iscd_pkg::iscd_store_t                       store,
    input  wire logic                                   memPending,
    output logic                                        syncActive,
    // exception unit
    output logic                                        exceptionValid,
    output iscd_pkg::iscd_exc_t                         exceptionKind,
    output logic                                        pairInhibit
);
    // ****************************************
    // operand selection
    // ****************************************
    iscd_pkg::iscd_op_t         op;
    iscd_pkg::iscd_shift_kind_t shiftKind;
    logic [31:0]                immSigned;
    logic [31:0]                cmpRhs;
    logic [31:0]                shiftOut;
    logic [4:0]                 shiftAmount;
    logic                       sLess;
    logic                       uLess;
    logic                       isEqual;
    logic [31:0]                diff;
    logic                       accept;

    function automatic logic [31:0] sext(input logic [31:0] v, input int top);
        logic [31:0] r;
        r = v;
        for (int i = 0; i < 32; i++) begin
            if (i > top) begin
                r[i] = v[top];
            end
        end
        return r;
    endfunction

    // a barrier holds issue until the memory side drains
    assign issueReady = !(syncActive && memPending);
    assign accept     = issueValid && issueReady;
    assign op         = issue.op;
    assign immSigned  = sext({16'h0000, issue.immediate}, iscd_pkg::HALF_TOP);

    always_comb begin
        shiftKind   = iscd_pkg::SHIFT_LEFT;
        shiftAmount = issue.shiftAmountField;
        case (op)
            iscd_pkg::OP_ROTATE_RIGHT_FIXED: begin
                shiftKind = iscd_pkg::SHIFT_ROTATE;
            end
            iscd_pkg::OP_ROTATE_RIGHT_VARIABLE: begin
                shiftKind   = iscd_pkg::SHIFT_ROTATE;
                shiftAmount = issue.firstSource[4:0];
            end
            iscd_pkg::OP_LEFT_SHIFT_VARIABLE: begin
                shiftAmount = issue.firstSource[4:0];
            end
            iscd_pkg::OP_ARITH_RIGHT_SHIFT_FIXED: begin
                shiftKind = iscd_pkg::SHIFT_RIGHT_ARITH;
            end
            iscd_pkg::OP_ARITH_RIGHT_SHIFT_VARIABLE: begin
                shiftKind   = iscd_pkg::SHIFT_RIGHT_ARITH;
                shiftAmount = issue.firstSource[4:0];
            end
            iscd_pkg::OP_LOGIC_RIGHT_SHIFT_FIXED: begin
                shiftKind = iscd_pkg::SHIFT_RIGHT_LOGIC;
            end
            iscd_pkg::OP_LOGIC_RIGHT_SHIFT_VARIABLE: begin
                shiftKind   = iscd_pkg::SHIFT_RIGHT_LOGIC;
                shiftAmount = issue.firstSource[4:0];
            end
            default: begin
                shiftKind = iscd_pkg::SHIFT_LEFT;
            end
        endcase
    end

    always_comb begin
        case (op)
            iscd_pkg::OP_SIGNED_LESS_THAN_IMM_SET,
            iscd_pkg::OP_UNSIGNED_LESS_THAN_IMM_SET,
            iscd_pkg::OP_TRAP_ON_EQUAL_IMM: cmpRhs = immSigned;
            default:                        cmpRhs = issue.secondSource;
        endcase
    end

    iscd_shifter u_shifter (
        .value  (issue.secondSource),
        .amount (shiftAmount),
        .kind   (shiftKind),
        .result (shiftOut)
    );

    iscd_compare u_compare (
        .lhs          (issue.firstSource),
        .rhs          (cmpRhs),
        .signedLess   (sLess),
        .unsignedLess (uLess),
        .equal        (isEqual),
        .difference   (diff)
    );

    assign shadowSet   = previousShadowSetField;
    assign shadowIndex = issue.shadowIndex;

    // ****************************************
    // result and side effects
    // ****************************************
    iscd_pkg::iscd_wb_t    next_writeBack;
    iscd_pkg::iscd_store_t next_store;
    logic                  next_exceptionValid;
    iscd_pkg::iscd_exc_t   next_exceptionKind;
    logic                  next_pairInhibit;
    logic                  next_syncActive;

    always_comb begin
        next_writeBack       = '0;
        next_store           = '0;
        next_exceptionValid  = 1'b0;
        next_exceptionKind   = iscd_pkg::EXC_NONE;
        next_pairInhibit     = 1'b0;
        next_syncActive      = syncActive && memPending;
        next_writeBack.index = issue.destIndex;
        if (accept) begin
            case (op)
                iscd_pkg::OP_ROTATE_RIGHT_FIXED, iscd_pkg::OP_ROTATE_RIGHT_VARIABLE,
                iscd_pkg::OP_LEFT_SHIFT_FIXED, iscd_pkg::OP_LEFT_SHIFT_VARIABLE,
                iscd_pkg::OP_ARITH_RIGHT_SHIFT_FIXED, iscd_pkg::OP_ARITH_RIGHT_SHIFT_VARIABLE,
                iscd_pkg::OP_LOGIC_RIGHT_SHIFT_FIXED, iscd_pkg::OP_LOGIC_RIGHT_SHIFT_VARIABLE: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = shiftOut;
                end
                iscd_pkg::OP_CONDITIONAL_STORE: begin
                    next_store.valid     = linkFlag;
                    next_store.addr      = issue.firstSource + immSigned;
                    next_store.data      = issue.secondSource;
                    next_writeBack.valid = 1'b1;
                    next_writeBack.index = issue.secondIndex;
                    next_writeBack.data  = linkFlag ? iscd_pkg::ONE_WORD : iscd_pkg::ZERO_WORD;
                end
                iscd_pkg::OP_DEBUG_BREAKPOINT_TRAP: begin
                    next_exceptionValid = 1'b1;
                    next_exceptionKind  = iscd_pkg::EXC_DEBUG;
                end
                iscd_pkg::OP_BYTE_SIGN_EXTEND: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = sext(issue.firstSource, iscd_pkg::BYTE_TOP);
                end
                iscd_pkg::OP_HALF_SIGN_EXTEND: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = sext(issue.firstSource, iscd_pkg::HALF_TOP);
                end
                iscd_pkg::OP_SIGNED_LESS_THAN_SET: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = sLess ? iscd_pkg::ONE_WORD : iscd_pkg::ZERO_WORD;
                end
                iscd_pkg::OP_SIGNED_LESS_THAN_IMM_SET: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.index = issue.secondIndex;
                    next_writeBack.data  = sLess ? iscd_pkg::ONE_WORD : iscd_pkg::ZERO_WORD;
                end
                iscd_pkg::OP_UNSIGNED_LESS_THAN_IMM_SET: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.index = issue.secondIndex;
                    next_writeBack.data  = uLess ? iscd_pkg::ONE_WORD : iscd_pkg::ZERO_WORD;
                end
                iscd_pkg::OP_UNSIGNED_LESS_THAN_SET: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = uLess ? iscd_pkg::ONE_WORD : iscd_pkg::ZERO_WORD;
                end
                iscd_pkg::OP_ISSUE_INHIBIT_NOOP: begin
                    next_pairInhibit = 1'b1;
                end
                iscd_pkg::OP_SIGNED_SUBTRACT: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = diff;
                end
                iscd_pkg::OP_UNSIGNED_SUBTRACT: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = diff;
                end
                iscd_pkg::OP_SYNC_BARRIER: begin
                    next_syncActive = 1'b1;
                end
                iscd_pkg::OP_TRAP_ON_EQUAL_REG: begin
                    next_exceptionValid = isEqual;
                    next_exceptionKind  = isEqual ? iscd_pkg::EXC_TRAP : iscd_pkg::EXC_NONE;
                end
                iscd_pkg::OP_TRAP_ON_EQUAL_IMM: begin
                    next_exceptionValid = isEqual;
                    next_exceptionKind  = isEqual ? iscd_pkg::EXC_TRAP : iscd_pkg::EXC_NONE;
                end
                iscd_pkg::OP_PREV_SHADOW_REG_READ: begin
                    next_writeBack.valid = 1'b1;
                    next_writeBack.data  = shadowData;
                end
                iscd_pkg::OP_SYSTEM_CALL_OP: begin
                    next_exceptionValid = 1'b1;
                    next_exceptionKind  = iscd_pkg::EXC_SYSTEM_CALL_OP;
                end
                default: begin
                    next_writeBack.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            writeBack      <= '0;
            store          <= '0;
            exceptionValid <= 1'b0;
            exceptionKind  <= iscd_pkg::EXC_NONE;
            pairInhibit    <= 1'b0;
            syncActive     <= 1'b0;
        end else begin
            writeBack      <= next_writeBack;
            store          <= next_store;
            exceptionValid <= next_exceptionValid;
            exceptionKind  <= next_exceptionKind;
            pairInhibit    <= next_pairInhibit;
            syncActive     <= next_syncActive;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_rotate_result: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_ROTATE_RIGHT_FIXED |=> writeBack.valid
        && writeBack.data == (($past(issue.secondSource) >> $past(issue.shiftAmountField))
        | ($past(issue.secondSource) << (6'd32 - $past(issue.shiftAmountField)))))
        else $error("rotate result wrong");
    a_store_gate: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_CONDITIONAL_STORE |=> store.valid == $past(linkFlag)
        && writeBack.data[0] == $past(linkFlag))
        else $error("conditional store gating wrong");
    a_debug_trap: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_DEBUG_BREAKPOINT_TRAP |=> exceptionValid
        && exceptionKind == iscd_pkg::EXC_DEBUG && !writeBack.valid)
        else $error("debug breakpoint did not trap");
    a_byte_extend: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_BYTE_SIGN_EXTEND |=>
        writeBack.data == {{24{$past(issue.firstSource[7])}}, $past(issue.firstSource[7:0])})
        else $error("byte sign extend wrong");
    a_signed_less: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_SIGNED_LESS_THAN_SET |=>
        writeBack.data == {31'h0, $signed($past(issue.firstSource)) < $signed($past(issue.secondSource))})
        else $error("signed compare wrong");
    a_noop_quiet: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_ISSUE_INHIBIT_NOOP |=> !writeBack.valid && !store.valid
        && !exceptionValid && pairInhibit)
        else $error("noop changed state");
    a_subtract_wrap: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_UNSIGNED_SUBTRACT |=>
        writeBack.data == $past(issue.firstSource) - $past(issue.secondSource))
        else $error("subtract wrong");
    a_sync_hold: assert property (@(posedge clock) disable iff (rst)
        syncActive && memPending |-> !issueReady
        ##1 (syncActive && !writeBack.valid && !store.valid && !exceptionValid))
        else $error("issue taken during barrier");
    a_equal_trap: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_TRAP_ON_EQUAL_REG |=>
        exceptionValid == ($past(issue.firstSource) == $past(issue.secondSource)))
        else $error("register trap wrong");
    a_system_call_op_raise: assert property (@(posedge clock) disable iff (rst)
        accept && op == iscd_pkg::OP_SYSTEM_CALL_OP |=> exceptionValid
        && exceptionKind == iscd_pkg::EXC_SYSTEM_CALL_OP && !writeBack.valid)
        else $error("system call wrong");
endmodule

// file: iscd_pkg.sv
package iscd_pkg;

    // ****************************************
    // operations
    // ****************************************
    typedef enum logic [4:0] {
        OP_NONE,
        OP_ROTATE_RIGHT_FIXED,
        OP_ROTATE_RIGHT_VARIABLE,
        OP_CONDITIONAL_STORE,
        OP_DEBUG_BREAKPOINT_TRAP,
        OP_BYTE_SIGN_EXTEND,
        OP_HALF_SIGN_EXTEND,
        OP_LEFT_SHIFT_FIXED,
        OP_LEFT_SHIFT_VARIABLE,
        OP_ARITH_RIGHT_SHIFT_FIXED,
        OP_ARITH_RIGHT_SHIFT_VARIABLE,
        OP_LOGIC_RIGHT_SHIFT_FIXED,
        OP_LOGIC_RIGHT_SHIFT_VARIABLE,
        OP_SIGNED_LESS_THAN_SET,
        OP_SIGNED_LESS_THAN_IMM_SET,
        OP_UNSIGNED_LESS_THAN_IMM_SET,
        OP_UNSIGNED_LESS_THAN_SET,
        OP_ISSUE_INHIBIT_NOOP,
        OP_SIGNED_SUBTRACT,
        OP_UNSIGNED_SUBTRACT,
        OP_SYNC_BARRIER,
        OP_TRAP_ON_EQUAL_REG,
        OP_TRAP_ON_EQUAL_IMM,
        OP_PREV_SHADOW_REG_READ,
        OP_SYSTEM_CALL_OP
    } iscd_op_t;

    typedef enum logic [1:0] {
        SHIFT_LEFT,
        SHIFT_RIGHT_LOGIC,
        SHIFT_RIGHT_ARITH,
        SHIFT_ROTATE
    } iscd_shift_kind_t;

    typedef enum logic [1:0] {
        EXC_NONE,
        EXC_TRAP,
        EXC_DEBUG,
        EXC_SYSTEM_CALL_OP
    } iscd_exc_t;

    // ****************************************
    // constants
    // ****************************************
    localparam int DATA_W      = 32;
    localparam int REG_IDX_W   = 5;
    localparam int SHADOW_W    = 4;
    localparam int SHAMT_W     = 5;
    localparam int IMM_W       = 16;
    localparam int BYTE_TOP    = 7;
    localparam int HALF_TOP    = 15;
    localparam int RESULT_LAT  = 1;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] ONE_WORD  = 32'h0000_0001;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        iscd_op_t               op;
        logic [DATA_W-1:0]      firstSource;
        logic [DATA_W-1:0]      secondSource;
        logic [SHAMT_W-1:0]     shiftAmountField;
        logic [IMM_W-1:0]       immediate;
        logic [REG_IDX_W-1:0]   destIndex;
        logic [REG_IDX_W-1:0]   secondIndex;
        logic [REG_IDX_W-1:0]   shadowIndex;
    } iscd_issue_t;

    typedef struct packed {
        logic                   valid;
        logic [REG_IDX_W-1:0]   index;
        logic [DATA_W-1:0]      data;
    } iscd_wb_t;

    typedef struct packed {
        logic                   valid;
        logic [DATA_W-1:0]      addr;
        logic [DATA_W-1:0]      data;
    } iscd_store_t;

endpackage

// file: iscd_shifter.sv
`timescale 1ns/100ps
module iscd_shifter (
    // operand
    input  wire logic [31:0]                value,
    input  wire logic [4:0]                 amount,
    input  wire iscd_pkg::iscd_shift_kind_t kind,
    // result
    output logic [31:0]                     result
);
    logic [63:0] rotWide;

    always_comb begin
        rotWide = {value, value} >> amount;
        case (kind)
            iscd_pkg::SHIFT_LEFT:        result = value << amount;
            iscd_pkg::SHIFT_RIGHT_LOGIC: result = value >> amount;
            iscd_pkg::SHIFT_RIGHT_ARITH: result = $unsigned($signed(value) >>> amount);
            iscd_pkg::SHIFT_ROTATE:      result = rotWide[31:0];
            default:                     result = value;
        endcase
    end
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    // ****************************************
    // signals
    // ****************************************
    logic                                      clock;
    logic                                      rst;
    logic                                      issueValid;
    logic                                      issueReady;
    iscd_pkg::iscd_issue_t                     issue;
    logic                                      linkFlag;
    logic [iscd_pkg::SHADOW_W-1:0]             previousShadowSetField;
    logic [iscd_pkg::SHADOW_W-1:0]             shadowSet;
    logic [iscd_pkg::REG_IDX_W-1:0]            shadowIndex;
    logic [iscd_pkg::DATA_W-1:0]               shadowData;
    iscd_pkg::iscd_wb_t                        writeBack;
    iscd_pkg::iscd_store_t                     store;
    logic                                      memPending;
    logic                                      syncActive;
    logic                                      exceptionValid;
    iscd_pkg::iscd_exc_t                       exceptionKind;
    logic                                      pairInhibit;
    int                                        errors;
    int                                        checks_done;
    iscd_pkg::iscd_issue_t                     cur;

    iscd_datapath uut (.clock(clock), .rst(rst), .issueValid(issueValid), .issueReady(issueReady),
        .issue(issue), .linkFlag(linkFlag), .previousShadowSetField(previousShadowSetField),
        .shadowSet(shadowSet), .shadowIndex(shadowIndex), .shadowData(shadowData),
        .writeBack(writeBack), .store(store), .memPending(memPending), .syncActive(syncActive),
        .exceptionValid(exceptionValid), .exceptionKind(exceptionKind), .pairInhibit(pairInhibit));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ****************************************
    // expectations
    // ****************************************
    function automatic logic [31:0] rotate_right_fixed(input logic [31:0] b, input logic [4:0] s);
        logic [63:0] t;
        t = {b, b} >> s;
        return t[31:0];
    endfunction

    function automatic logic [31:0] sext(input logic [15:0] m);
        return {{16{m[15]}}, m};
    endfunction

    function automatic iscd_pkg::iscd_wb_t exp_wb(input iscd_pkg::iscd_issue_t i, input logic lf,
                                                  input logic [31:0] sh);
        iscd_pkg::iscd_wb_t w;
        logic [31:0]        a;
        logic [31:0]        b;
        logic [31:0]        m;
        logic [4:0]         v;
        a = i.firstSource;
        b = i.secondSource;
        m = sext(i.immediate);
        v = a[4:0];
        w = '0;
        w.valid = 1'b1;
        w.index = i.destIndex;
        case (i.op)
            iscd_pkg::OP_ROTATE_RIGHT_FIXED:         w.data = rotate_right_fixed(b, i.shiftAmountField);
            iscd_pkg::OP_ROTATE_RIGHT_VARIABLE:      w.data = rotate_right_fixed(b, v);
            iscd_pkg::OP_CONDITIONAL_STORE:          w.data = {31'h0, lf};
            iscd_pkg::OP_BYTE_SIGN_EXTEND:           w.data = {{24{a[7]}}, a[7:0]};
            iscd_pkg::OP_HALF_SIGN_EXTEND:           w.data = {{16{a[15]}}, a[15:0]};
            iscd_pkg::OP_LEFT_SHIFT_FIXED:           w.data = b << i.shiftAmountField;
            iscd_pkg::OP_LEFT_SHIFT_VARIABLE:        w.data = b << v;
            iscd_pkg::OP_ARITH_RIGHT_SHIFT_FIXED:    w.data = 32'($signed(b) >>> i.shiftAmountField);
            iscd_pkg::OP_ARITH_RIGHT_SHIFT_VARIABLE: w.data = 32'($signed(b) >>> v);
            iscd_pkg::OP_LOGIC_RIGHT_SHIFT_FIXED:    w.data = b >> i.shiftAmountField;
            iscd_pkg::OP_LOGIC_RIGHT_SHIFT_VARIABLE: w.data = b >> v;
            iscd_pkg::OP_SIGNED_LESS_THAN_SET:       w.data = {31'h0, $signed(a) < $signed(b)};
            iscd_pkg::OP_SIGNED_LESS_THAN_IMM_SET:   w.data = {31'h0, $signed(a) < $signed(m)};
            iscd_pkg::OP_UNSIGNED_LESS_THAN_IMM_SET: w.data = {31'h0, a < m};
            iscd_pkg::OP_UNSIGNED_LESS_THAN_SET:     w.data = {31'h0, a < b};
            iscd_pkg::OP_SIGNED_SUBTRACT:            w.data = a - b;
            iscd_pkg::OP_UNSIGNED_SUBTRACT:          w.data = a - b;
            iscd_pkg::OP_PREV_SHADOW_REG_READ:       w.data = sh;
            default:                                 w.valid = 1'b0;
        endcase
        if (i.op inside {iscd_pkg::OP_CONDITIONAL_STORE, iscd_pkg::OP_SIGNED_LESS_THAN_IMM_SET,
                         iscd_pkg::OP_UNSIGNED_LESS_THAN_IMM_SET}) begin
            w.index = i.secondIndex;
        end
        return w;
    endfunction

    function automatic iscd_pkg::iscd_exc_t exp_exc(input iscd_pkg::iscd_issue_t i);
        case (i.op)
            iscd_pkg::OP_DEBUG_BREAKPOINT_TRAP: return iscd_pkg::EXC_DEBUG;
            iscd_pkg::OP_TRAP_ON_EQUAL_REG:
                return (i.firstSource == i.secondSource) ? iscd_pkg::EXC_TRAP : iscd_pkg::EXC_NONE;
            iscd_pkg::OP_TRAP_ON_EQUAL_IMM:
                return (i.firstSource == sext(i.immediate)) ? iscd_pkg::EXC_TRAP : iscd_pkg::EXC_NONE;
            iscd_pkg::OP_SYSTEM_CALL_OP:        return iscd_pkg::EXC_SYSTEM_CALL_OP;
            default:                            return iscd_pkg::EXC_NONE;
        endcase
    endfunction

    // ****************************************
    // driver and checks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // drives one request and checks its answer one edge later, so calls run back to back
    task automatic run_op(input iscd_pkg::iscd_issue_t i, input logic lf);
        iscd_pkg::iscd_wb_t  w;
        iscd_pkg::iscd_exc_t e;
        logic [31:0]         sh;
        logic                sv;
        sh = $urandom;
        issue = i;
        linkFlag = lf;
        shadowData = sh;
        previousShadowSetField = 4'($urandom);
        issueValid = 1'b1;
        w = exp_wb(i, lf, sh);
        e = exp_exc(i);
        sv = (i.op == iscd_pkg::OP_CONDITIONAL_STORE) && lf;
        @(posedge clock);
        #1;
        check(32'(shadowSet), 32'(previousShadowSetField));
        check(32'(shadowIndex), 32'(i.shadowIndex));
        check(32'(writeBack.valid), 32'(w.valid));
        if (w.valid === 1'b1) begin
            check(32'(writeBack.index), 32'(w.index));
            check(writeBack.data, w.data);
        end
        check(32'(store.valid), 32'(sv));
        if (sv) begin
            check(store.addr, i.firstSource + sext(i.immediate));
            check(store.data, i.secondSource);
        end
        check(32'(exceptionValid), 32'(e != iscd_pkg::EXC_NONE));
        check(32'(exceptionKind), 32'(e));
        check(32'(pairInhibit), 32'(i.op == iscd_pkg::OP_ISSUE_INHIBIT_NOOP));
        check(32'(syncActive), 32'(i.op == iscd_pkg::OP_SYNC_BARRIER));
    endtask

    function automatic logic [31:0] rnd_word();
        case ($urandom % 8)
            0:       return 32'h0000_0000;
            1:       return 32'hffff_ffff;
            2:       return 32'h8000_0000;
            3:       return 32'h7fff_ffff;
            default: return $urandom;
        endcase
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        #100000;
        errors++;
        end_of_test();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        rst = 1'b1;
        issueValid = 1'b0;
        issue = '0;
        linkFlag = 1'b0;
        previousShadowSetField = 4'h0;
        shadowData = 32'h0000_0000;
        memPending = 1'b0;
        void'($urandom(63));
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        check(32'({writeBack.valid, store.valid, exceptionValid, pairInhibit, syncActive, issueReady}), 32'h1);
        $display("reset test done");
        // every operation once with sign and boundary heavy operands, then store and equal trap corner cases, then an unknown code
        cur = '0;
        cur.firstSource = 32'h8000_00f1;
        cur.secondSource = 32'hf00f_0081;
        cur.shiftAmountField = 5'h1f;
        cur.immediate = 16'h8001;
        cur.destIndex = 5'h03;
        cur.secondIndex = 5'h03;
        cur.shadowIndex = 5'h1e;
        for (int k = 0; k < 25; k++) begin
            cur.op = iscd_pkg::iscd_op_t'(k);
            run_op(cur, 1'b1);
        end
        cur.op = iscd_pkg::OP_CONDITIONAL_STORE;
        run_op(cur, 1'b0);
        cur.secondSource = cur.firstSource;
        cur.op = iscd_pkg::OP_TRAP_ON_EQUAL_REG;
        run_op(cur, 1'b0);
        cur.firstSource = 32'hffff_8001;
        cur.op = iscd_pkg::OP_TRAP_ON_EQUAL_IMM;
        run_op(cur, 1'b0);
        cur.op = iscd_pkg::iscd_op_t'(5'h1f);
        run_op(cur, 1'b1);
        $display("sweep test done");
        for (int n = 0; n < 400; n++) begin
            cur.op = iscd_pkg::iscd_op_t'($urandom % 25);
            cur.firstSource = rnd_word();
            cur.secondSource = ($urandom % 4 == 0) ? cur.firstSource : rnd_word();
            cur.shiftAmountField = 5'($urandom);
            cur.immediate = 16'($urandom);
            if ($urandom % 4 == 0) cur.firstSource = sext(cur.immediate);
            cur.destIndex = 5'($urandom);
            // destination naming of the shadow read is loose, so both indexes agree there
            cur.secondIndex = (cur.op == iscd_pkg::OP_PREV_SHADOW_REG_READ) ? cur.destIndex : 5'($urandom);
            cur.shadowIndex = 5'($urandom);
            run_op(cur, 1'($urandom));
        end
        $display("random test done");
        // barrier holds off a waiting subtract while memory is still busy
        memPending = 1'b1;
        cur.op = iscd_pkg::OP_SYNC_BARRIER;
        run_op(cur, 1'b0);
        check(32'(issueReady), 32'h0);
        cur.op = iscd_pkg::OP_UNSIGNED_SUBTRACT;
        issue = cur;
        repeat (3) begin
            @(posedge clock);
            #1;
            check({31'h0, writeBack.valid | issueReady}, 32'h0);
        end
        memPending = 1'b0;
        @(posedge clock);
        #1;
        check({30'h0, writeBack.valid, syncActive}, 32'h2);
        check(writeBack.data, cur.firstSource - cur.secondSource);
        $display("barrier test done");
        memPending = 1'b1;
        cur.op = iscd_pkg::OP_SYNC_BARRIER;
        run_op(cur, 1'b0);
        issueValid = 1'b0;
        rst = 1'b1;
        @(posedge clock);
        #1;
        rst = 1'b0;
        check({30'h0, syncActive, issueReady}, 32'h1);
        memPending = 1'b0;
        $display("mid run reset test done");
        end_of_test();
    end
endmodule
